/* File: logic/tmc_pkg.sv */
/*
 tmc_pkg: register indices, field positions, reset values, clock codes
 and the state record of the 16-bit timer control block.
 assumes: byte address of a register is four times its index.
*/
`default_nettype none
package tmc_pkg;
    // register indices
    localparam logic [7:0] IDX_CTRL_A  = 8'h80;
    localparam logic [7:0] IDX_CTRL_B  = 8'h81;
    localparam logic [7:0] IDX_FORCE   = 8'h82;
    localparam logic [7:0] IDX_CNT_L   = 8'h84;
    localparam logic [7:0] IDX_CNT_H   = 8'h85;
    localparam logic [7:0] IDX_CAP_L   = 8'h86;
    localparam logic [7:0] IDX_CAP_H   = 8'h87;
    localparam logic [7:0] IDX_CMPA_L  = 8'h88;
    localparam logic [7:0] IDX_CMPA_H  = 8'h89;
    localparam logic [7:0] IDX_CMPB_L  = 8'h8A;
    localparam logic [7:0] IDX_CMPB_H  = 8'h8B;
    localparam logic [7:0] IDX_FLAGS   = 8'h90;
    // writable bits
    localparam logic [7:0] CTRL_A_MASK = 8'hF3;
    localparam logic [7:0] CTRL_B_MASK = 8'hDF;
    // field positions
    localparam int CB_NOISE   = 7;
    localparam int CB_EDGE    = 6;
    localparam int CB_WGM_HI  = 3;
    localparam int FRC_A_BIT  = 7;
    localparam int FRC_B_BIT  = 6;
    localparam int FL_CAP     = 5;
    localparam int FL_CMPB    = 2;
    localparam int FL_CMPA    = 1;
    localparam int FL_OVF     = 0;
    // clock source codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_D64  = 3'h3;
    localparam logic [2:0] CS_D256 = 3'h4;
    localparam logic [2:0] CS_D1K  = 3'h5;
    localparam logic [2:0] CS_EXTF = 3'h6;
    localparam logic [2:0] CS_EXTR = 3'h7;
    // fixed tops
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8B  = 16'h00FF;
    localparam logic [15:0] TOP_9B  = 16'h01FF;
    localparam logic [15:0] TOP_10B = 16'h03FF;
    localparam int NOISE_LEN = 4;
    localparam logic [7:0] REG_RST = 8'h00;

    typedef struct packed {
        logic [7:0]           ctrl_a;
        logic [7:0]           ctrl_b;
        logic [7:0]           temp;
        logic [15:0]          cnt;
        logic                 dir_down;
        logic [15:0]          cmpa_buf;
        logic [15:0]          cmpa;
        logic [15:0]          cmpb_buf;
        logic [15:0]          cmpb;
        logic [15:0]          cap;
        logic [9:0]           presc;
        logic                 ext_prev;
        logic [NOISE_LEN-1:0] cap_hist;
        logic                 cap_filt;
        logic                 blk_match;
        logic [7:0]           flags;
        logic                 wr_pend;
        logic [7:0]           wr_idx;
        logic [31:0]          hrdata;
        logic                 hreadyout;
        logic                 frc_a;
        logic                 frc_b;
        logic                 tick;
    } tmc_state_t;

    localparam tmc_state_t ST_RST = '{hreadyout: 1'b1, default: '0};
endpackage
`default_nettype wire

/* File: logic/tmc_top.sv */
/*
 tmc_top: mode decode, clock select, capture front end, forced compare
 strobes and 16-bit counter access of a 16-bit timer, AHB-Lite slave.
 assumes: one clock, pins synchronous to clk_sys, waveform unit outside.
*/
// The AHB-Lite register port is this design's own decision.
// Overview of operation
// - mode is two low bits of control A with two bits of control B
// - mode 0 free counts to 0xFFFF; modes 4 and 12 clear at compare A/capture
// - modes 1-3 phase correct 8/9/10 bit, load at top, overflow at bottom
// - fast, phase-frequency and phase correct variants; mode 13 reserved
// - noise filter needs four equal samples before the input changes
// - edge select zero means falling edge, one means rising edge
// - qualified capture edge copies counter to capture register, sets flag
// - capture input ignored when capture register serves as top
// - clock codes: stop, /1, /8, /64, /256, /1024
// - codes 110 and 111 count falling or rising count pin edges
// - count pin edges count regardless of pin direction
// - force compare bits act only in non-PWM modes
// - force bit one pulses an immediate match to the waveform unit
// - forced match sets no flag and never clears the counter
// - force compare bits always read as zero
// - 16-bit accesses go through one shared high-byte latch
// - counter write blocks compare matches on the next timer clock
// - match flag sets on the timer clock while counter equals compare
`timescale 1ns/1ps
`default_nettype none
module tmc_top
    import tmc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              capture_input_pin,
    input  wire logic              ext_count_pin,
    output logic      [15:0]       counter_value,
    output logic                   timer_tick,
    output logic                   force_compare_a,
    output logic                   force_compare_b,
    output logic      [1:0]        compare_output_mode_a,
    output logic      [1:0]        compare_output_mode_b,
    output logic                   overflow_flag,
    output logic                   capture_flag,
    output logic                   compare_match_flag_a,
    output logic                   compare_match_flag_b
);

    tmc_state_t st;
    tmc_state_t next_st;

    logic [3:0]  wgm;
    logic [2:0]  csel;
    logic        pwm;
    logic        phase;
    logic        fast;
    logic        imm;
    logic        upd_top;
    logic        cap_top;
    logic [15:0] top;
    logic        tick;
    logic        at_top;
    logic        at_bot;
    logic        ev_top;
    logic        ev_bot;
    logic        cap_edge;
    logic [7:0]  fl_set;
    logic [7:0]  fl_clr;
    logic [7:0]  wd;
    logic [7:0]  ridx;
    logic        acc;

    ////////////////////////////////////////////////////////////////////
    // mode decode

    always_comb begin
        wgm     = {st.ctrl_b[CB_WGM_HI+1:CB_WGM_HI], st.ctrl_a[1:0]};
        csel    = st.ctrl_b[2:0];
        imm     = (wgm == 4'd0) || (wgm == 4'd4) || (wgm == 4'd12);
        pwm     = !imm;
        phase   = (wgm >= 4'd1 && wgm <= 4'd3) || (wgm >= 4'd8 && wgm <= 4'd11);
        fast    = (wgm >= 4'd5 && wgm <= 4'd7) || (wgm >= 4'd14);
        upd_top = (wgm >= 4'd1 && wgm <= 4'd3) || (wgm == 4'd10) || (wgm == 4'd11);
        cap_top = (wgm == 4'd8) || (wgm == 4'd10) || (wgm == 4'd12) || (wgm == 4'd14);
        case (wgm)
            4'd1, 4'd5:                 top = TOP_8B;
            4'd2, 4'd6:                 top = TOP_9B;
            4'd3, 4'd7:                 top = TOP_10B;
            4'd4, 4'd9, 4'd11, 4'd15:   top = st.cmpa;
            4'd8, 4'd10, 4'd12, 4'd14:  top = st.cap;
            default:                    top = TOP_MAX;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // clock select; prescaler runs freely so taps stay aligned

    always_comb begin
        case (csel)
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = &st.presc[2:0];
            CS_D64:  tick = &st.presc[5:0];
            CS_D256: tick = &st.presc[7:0];
            CS_D1K:  tick = &st.presc[9:0];
            CS_EXTF: tick = st.ext_prev && !ext_count_pin;
            CS_EXTR: tick = !st.ext_prev && ext_count_pin;
            default: tick = 1'b0;
        endcase
        at_top = (st.cnt == top);
        at_bot = (st.cnt == 16'h0000);
        ev_top = tick && at_top && (!phase || !st.dir_down);
        ev_bot = tick && phase && at_bot && st.dir_down;
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st          = st;
        fl_set           = 8'h00;
        fl_clr           = 8'h00;
        wd               = hwdata[7:0];
        ridx             = haddr[9:2];
        acc              = hsel && hready && htrans[1] && (haddr[ADDR_W-1:10] == '0)
                           && (haddr[1:0] == 2'b00);
        cap_edge         = 1'b0;
        next_st.frc_a    = 1'b0;
        next_st.frc_b    = 1'b0;
        next_st.tick     = tick;
        next_st.hreadyout = 1'b1;
        next_st.presc    = st.presc + 10'd1;
        next_st.ext_prev = ext_count_pin;

        // capture front end
        next_st.cap_hist = {st.cap_hist[NOISE_LEN-2:0], capture_input_pin};
        if (st.ctrl_b[CB_NOISE]) begin
            if (&st.cap_hist) begin
                next_st.cap_filt = 1'b1;
            end else if (~|st.cap_hist) begin
                next_st.cap_filt = 1'b0;
            end
        end else begin
            next_st.cap_filt = st.cap_hist[0];
        end
        if (next_st.cap_filt != st.cap_filt) begin
            cap_edge = (next_st.cap_filt == st.ctrl_b[CB_EDGE]);
        end
        if (cap_edge && !cap_top) begin
            next_st.cap = st.cnt;
            fl_set[FL_CAP] = 1'b1;
        end

        // counting, only on the timer clock
        if (tick) begin
            if (phase) begin
                if (st.dir_down) begin
                    if (at_bot) begin
                        next_st.dir_down = 1'b0;
                        next_st.cnt = st.cnt + 16'd1;
                    end else begin
                        next_st.cnt = st.cnt - 16'd1;
                    end
                end else if (at_top) begin
                    next_st.dir_down = 1'b1;
                    next_st.cnt = st.cnt - 16'd1;
                end else begin
                    next_st.cnt = st.cnt + 16'd1;
                end
            end else if (wgm != 4'd0 && at_top) begin
                next_st.cnt = 16'h0000;
            end else begin
                next_st.cnt = st.cnt + 16'd1;
            end
            if (!phase) begin
                next_st.dir_down = 1'b0;
            end
            if (imm && st.cnt == TOP_MAX) begin
                fl_set[FL_OVF] = 1'b1;
            end
            if (!st.blk_match) begin
                fl_set[FL_CMPA] = (st.cnt == st.cmpa);
                fl_set[FL_CMPB] = (st.cnt == st.cmpb);
            end
            next_st.blk_match = 1'b0;
        end
        if (fast && ev_top) begin
            fl_set[FL_OVF] = 1'b1;
        end
        if (ev_bot) begin
            fl_set[FL_OVF] = 1'b1;
        end
        if (cap_top && ev_top) begin
            fl_set[FL_CAP] = 1'b1;
        end

        // compare buffer loading point
        if (imm) begin
            next_st.cmpa = st.cmpa_buf;
            next_st.cmpb = st.cmpb_buf;
        end else if ((upd_top && ev_top) || (fast && ev_top) || (!upd_top && ev_bot)) begin
            next_st.cmpa = st.cmpa_buf;
            next_st.cmpb = st.cmpb_buf;
        end

        // bus address phase, reads answered from here
        next_st.wr_pend = acc && hwrite;
        next_st.wr_idx  = ridx;
        if (acc && !hwrite) begin
            case (ridx)
                IDX_CTRL_A: next_st.hrdata = {24'h0, st.ctrl_a};
                IDX_CTRL_B: next_st.hrdata = {24'h0, st.ctrl_b};
                IDX_CNT_L: begin
                    next_st.hrdata = {24'h0, st.cnt[7:0]};
                    next_st.temp   = st.cnt[15:8];
                end
                IDX_CAP_L: begin
                    next_st.hrdata = {24'h0, st.cap[7:0]};
                    next_st.temp   = st.cap[15:8];
                end
                IDX_CMPA_L: begin
                    next_st.hrdata = {24'h0, st.cmpa_buf[7:0]};
                    next_st.temp   = st.cmpa_buf[15:8];
                end
                IDX_CMPB_L: begin
                    next_st.hrdata = {24'h0, st.cmpb_buf[7:0]};
                    next_st.temp   = st.cmpb_buf[15:8];
                end
                IDX_CNT_H, IDX_CAP_H, IDX_CMPA_H, IDX_CMPB_H: begin
                    next_st.hrdata = {24'h0, st.temp};
                end
                IDX_FLAGS:  next_st.hrdata = {24'h0, st.flags};
                default:    next_st.hrdata = 32'h0000_0000;
            endcase
        end

        // bus data phase, writes land here and win over counting
        if (st.wr_pend) begin
            case (st.wr_idx)
                IDX_CTRL_A: next_st.ctrl_a = wd & CTRL_A_MASK;
                IDX_CTRL_B: next_st.ctrl_b = wd & CTRL_B_MASK;
                IDX_FORCE: begin
                    if (!pwm) begin
                        next_st.frc_a = wd[FRC_A_BIT];
                        next_st.frc_b = wd[FRC_B_BIT];
                    end
                end
                IDX_CNT_L: begin
                    next_st.cnt       = {st.temp, wd};
                    next_st.blk_match = 1'b1;
                end
                IDX_CAP_L: next_st.cap = {st.temp, wd};
                IDX_CMPA_L: begin
                    next_st.cmpa_buf = {st.temp, wd};
                    if (imm) begin
                        next_st.cmpa = {st.temp, wd};
                    end
                end
                IDX_CMPB_L: begin
                    next_st.cmpb_buf = {st.temp, wd};
                    if (imm) begin
                        next_st.cmpb = {st.temp, wd};
                    end
                end
                IDX_CNT_H, IDX_CAP_H, IDX_CMPA_H, IDX_CMPB_H: begin
                    next_st.temp = wd;
                end
                IDX_FLAGS: fl_clr = wd;
                default: ;
            endcase
        end
        // a flag set in the clearing cycle survives
        next_st.flags = ((st.flags & ~fl_clr) | fl_set) & 8'h27;
    end

    ////////////////////////////////////////////////////////////////////
    // state register; clock enable freezes bus answers too

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= ST_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign hrdata                = st.hrdata;
    assign hreadyout             = st.hreadyout;
    assign hresp                 = 1'b0;
    assign counter_value         = st.cnt;
    assign timer_tick            = st.tick;
    assign force_compare_a       = st.frc_a;
    assign force_compare_b       = st.frc_b;
    assign compare_output_mode_a = st.ctrl_a[7:6];
    assign compare_output_mode_b = st.ctrl_a[5:4];
    assign overflow_flag         = st.flags[FL_OVF];
    assign capture_flag          = st.flags[FL_CAP];
    assign compare_match_flag_a  = st.flags[FL_CMPA];
    assign compare_match_flag_b  = st.flags[FL_CMPB];

endmodule
`default_nettype wire

/* File: bench/tmc_assertions.sv */
/* tmc_assertions: port checker for tmc_top, bound below.
 assumes: one clock, hready fed back from hreadyout, mode shadowed from bus writes. */
`timescale 1ns/1ps
`default_nettype none
module tmc_assertions
    import tmc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic              clk_en,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hwdata,
    input wire logic              ext_count_pin,
    input wire logic [15:0]       counter_value,
    input wire logic              timer_tick,
    input wire logic              force_compare_a,
    input wire logic              force_compare_b,
    input wire logic              overflow_flag,
    input wire logic              capture_flag,
    input wire logic              compare_match_flag_a
);
    logic       pend;
    logic [7:0] pidx;
    logic [7:0] sh_a;
    logic [7:0] sh_b;
    logic [3:0] mode;
    logic       wr_cnt;
    assign mode   = {sh_b[4:3], sh_a[1:0]};
    assign wr_cnt = pend && pidx == IDX_CNT_L;
    // shadow follows the design: frozen while clk_en is low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pend <= 1'b0;
            pidx <= 8'h00;
            sh_a <= 8'h00;
            sh_b <= 8'h00;
        end else if (clk_en) begin
            pend <= hsel && hready && htrans[1] && hwrite;
            pidx <= haddr[9:2];
            if (pend && pidx == IDX_CTRL_A) sh_a <= hwdata[7:0];
            if (pend && pidx == IDX_CTRL_B) sh_b <= hwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_cnt_hold: assert property ($changed(counter_value) |-> timer_tick || $past(wr_cnt))
        else $error("counter moved without tick or write");
    chk_stop_tick: assert property ($past(sh_b[2:0]) == CS_STOP && $past(clk_en) |-> !timer_tick)
        else $error("tick while stopped");
    chk_div1_tick: assert property ($past(sh_b[2:0]) == CS_DIV1 && $past(clk_en) |-> timer_tick)
        else $error("missing undivided tick");
    chk_div8_gap: assert property (timer_tick && $past(sh_b[2:0]) == CS_DIV8
        |=> (!timer_tick || $past(sh_b[2:0]) != CS_DIV8) [*7])
        else $error("divide by eight spacing wrong");
    chk_ext_edge: assert property ($past(sh_b[2:1]) == 2'b11 && $past(clk_en) && $past(clk_en, 2)
        |-> timer_tick == ($past(ext_count_pin) != $past(ext_count_pin, 2)
        && $past(ext_count_pin) == $past(sh_b[0])))
        else $error("count pin edge not followed");
    chk_ovf_max: assert property ($rose(overflow_flag) && mode == 4'h0
        |-> $past(counter_value) == TOP_MAX && counter_value == 16'h0000)
        else $error("normal mode overflow not at max");
    chk_ovf_tick: assert property ($rose(overflow_flag) |-> timer_tick)
        else $error("overflow flag off tick");
    chk_cmp_tick: assert property ($rose(compare_match_flag_a) |-> timer_tick)
        else $error("match flag off tick");
    chk_force_pulse: assert property (force_compare_a || force_compare_b
        |=> !(force_compare_a || force_compare_b))
        else $error("force strobe longer than one cycle");
    chk_force_pwm: assert property (force_compare_a || force_compare_b
        |-> $past(mode) inside {4'h0, 4'h4, 4'hC})
        else $error("force strobe in pwm mode");
    cov_ovf: cover property ($rose(overflow_flag));
    cov_cap: cover property ($rose(capture_flag));
    cov_cmp: cover property ($rose(compare_match_flag_a));
    cov_force: cover property (force_compare_a);
endmodule
bind tmc_top tmc_assertions #(.ADDR_W(ADDR_W)) u_tmc_assertions (
    .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .ext_count_pin(ext_count_pin),
    .counter_value(counter_value), .timer_tick(timer_tick), .force_compare_a(force_compare_a),
    .force_compare_b(force_compare_b), .overflow_flag(overflow_flag), .capture_flag(capture_flag),
    .compare_match_flag_a(compare_match_flag_a));
`default_nettype wire

/* File: bench/tmc_pin_drv.sv */
/* tmc_pin_drv: drives the capture and count pins from the outside.
 assumes: pins are sampled on clk_sys, so changes land just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_drv (
    input  wire logic clk_sys,
    output logic      capture_input_pin,
    output logic      ext_count_pin
);
    initial begin
        capture_input_pin = 1'b1;
        ext_count_pin     = 1'b0;
    end
    // flip, hold n cycles, optionally flip back; short holds make glitches
    task automatic cap_drive(input int n, input logic back);
        @(posedge clk_sys);
        capture_input_pin <= ~capture_input_pin;
        repeat (n) @(posedge clk_sys);
        if (back) capture_input_pin <= ~capture_input_pin;
        repeat (12) @(posedge clk_sys);
    endtask
    // pin is an input here only; direction does not matter to counting
    task automatic ext_toggle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ext_count_pin <= ~ext_count_pin;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/timer16_mode_clock_capture_tb_top.sv */
/* timer16_mode_clock_capture_tb_top: self-checking bench for tmc_top.
 assumes: zero wait state slave, reads checked by a monitor from a queue. */
`timescale 1ns/1ps
`default_nettype none
module timer16_mode_clock_capture_tb_top import tmc_pkg::*;;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic        clk_en  = 1'b1;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        rd_chk  = 1'b0;
    logic [1:0]  htrans  = 2'b00;
    logic [11:0] haddr   = 12'h000;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [31:0] hrdata, r;
    logic [15:0] cnt;
    logic        hreadyout, hresp, cap_pin, ext_pin, tick, fca, fcb, ovf, capf, cmpa;
    int          num_errors = 0, checked = 0, cycles = 0, fcnt = 0, n;
    int          seed = 32'hd5cf;
    int          dv[5] = '{2, 8, 64, 256, 1024};
    logic [31:0] exp_q[$];
    string       name_q[$];
    tmc_top #(.ADDR_W(12)) u_tmc_top (
        .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(cap_pin), .ext_count_pin(ext_pin),
        .counter_value(cnt), .timer_tick(tick), .force_compare_a(fca), .force_compare_b(fcb),
        .compare_output_mode_a(), .compare_output_mode_b(), .overflow_flag(ovf), .capture_flag(capf),
        .compare_match_flag_a(cmpa), .compare_match_flag_b());
    tmc_pin_drv u_tmc_pin_drv (.clk_sys(clk_sys), .capture_input_pin(cap_pin), .ext_count_pin(ext_pin));
    always #20 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // prescaler phase and bus overhead leave a few ticks of slack
    task automatic cmp_near(input string nm, input int e, input logic [15:0] s);
        int d;
        d = int'(s) - e;
        checked++;
        if ($isunknown(s) || d < -4 || d > 4) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %h", nm, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic chk);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {2'b00, idx, 2'b00};
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        rd_chk <= chk;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd_chk <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 1'b0);
    endtask
    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
        name_q.push_back(nm);
        exp_q.push_back({24'h00_0000, e});
        xfer(1'b0, idx, 8'h00, 1'b1);
    endtask
    // high byte first on write, low byte first on read: shared latch
    task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx + 8'h01, v[15:8]);
        wr(idx, v[7:0]);
    endtask
    task automatic rd16(input string nm, input logic [7:0] idx, input logic [15:0] v);
        rd(nm, idx, v[7:0]);
        rd(nm, idx + 8'h01, v[15:8]);
    endtask
    task automatic setm(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] b76);
        wr(IDX_CTRL_A, {6'h00, m[1:0]});
        wr(IDX_CTRL_B, {b76, 1'b0, m[3:2], cs});
    endtask
    task automatic run(input int k);
        wr(IDX_CTRL_B, {5'h00, CS_DIV1});
        repeat (k) @(posedge clk_sys);
        wr(IDX_CTRL_B, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (rd_chk === 1'b1 && hreadyout === 1'b1) cmp_word(name_q.pop_front(), exp_q.pop_front(), hrdata);
        if (rd_chk === 1'b1) cmp_word("hresp", 0, hresp);
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        fcnt   <= fcnt + (fca === 1'b1) + (fcb === 1'b1);
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rd("ctrl_b reset", IDX_CTRL_B, REG_RST);
        rd("flags reset", IDX_FLAGS, 8'h00);
        wr(8'hFF, 8'hFF);
        rd("unmapped", 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(IDX_CTRL_A, r[7:0]);
            wr(IDX_CTRL_B, r[15:8] & 8'hD8);
            rd("ctrl_a", IDX_CTRL_A, r[7:0] & CTRL_A_MASK);
            rd("ctrl_b", IDX_CTRL_B, r[15:8] & 8'hD8);
        end
        wr(IDX_CMPA_H, 8'h12);
        wr(IDX_CNT_L, 8'h34);
        rd16("counter via shared latch", IDX_CNT_L, 16'h1234);
        wr16(IDX_CNT_L, r[31:16]);
        rd16("counter", IDX_CNT_L, r[31:16]);
        for (int m = 0; m < 16; m++) begin
            setm(m[3:0], CS_STOP, 2'b00);
            n = fcnt;
            wr(IDX_FORCE, (m == 0 || m == 4 || m == 12) ? 8'hC0 : 8'h00);
            repeat (2) @(posedge clk_sys);
            cmp_word("force strobes", (m == 0 || m == 4 || m == 12) ? 2 : 0, fcnt - n);
        end
        rd("force reads", IDX_FORCE, 8'h00);
        rd("forced no flag", IDX_FLAGS, 8'h00);
        rd16("forced no clear", IDX_CNT_L, r[31:16]);
        setm(4'h0, CS_STOP, 2'b00);
        wr16(IDX_CMPA_L, 16'h0040);
        wr16(IDX_CNT_L, 16'h0040);
        wr(IDX_FLAGS, 8'hFF);
        run(40);
        rd("blocked match", IDX_FLAGS, 8'h00);
        wr16(IDX_CNT_L, 16'h003E);
        run(40);
        rd("match flag", IDX_FLAGS, 8'h02);
        wr16(IDX_CNT_L, 16'hFFF0);
        wr(IDX_FLAGS, 8'hFF);
        run(40);
        rd("overflow and wrap match", IDX_FLAGS, 8'h05);
        wr16(IDX_CNT_L, 16'h5A5A);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CTRL_B, {1'b0, i[1], 6'h00});
            wr(IDX_FLAGS, 8'hFF);
            u_tmc_pin_drv.cap_drive(1, 1'b0);
            rd("capture edge", IDX_FLAGS, (i == 0 || i == 3) ? 8'h20 : 8'h00);
        end
        rd16("capture value", IDX_CAP_L, 16'h5A5A);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_CTRL_B, {i != 0, 7'h00});
            wr(IDX_FLAGS, 8'hFF);
            u_tmc_pin_drv.cap_drive(3, i < 2);
            rd("capture filter", IDX_FLAGS, (i == 1) ? 8'h00 : 8'h20);
        end
        setm(4'hC, CS_STOP, 2'b01);
        wr16(IDX_CAP_L, 16'h1234);
        wr(IDX_FLAGS, 8'hFF);
        u_tmc_pin_drv.cap_drive(1, 1'b0);
        rd16("capture disconnected", IDX_CAP_L, 16'h1234);
        setm(4'h0, CS_STOP, 2'b00);
        for (int c = 1; c < 8; c++) begin
            wr16(IDX_CNT_L, 16'h0000);
            wr(IDX_CTRL_B, {5'h00, c[2:0]});
            if (c > 5) u_tmc_pin_drv.ext_toggle(2 * c - 7);
            for (int k = 0; k < 2048 && c < 6; k++) begin
                @(posedge clk_sys);
                clk_en <= (c != 1) || k[0];
            end
            @(posedge clk_sys);
            clk_en <= 1'b1;
            wr(IDX_CTRL_B, 8'h00);
            @(posedge clk_sys);
            if (c < 6) cmp_near("prescaled count", 2048 / dv[c-1], cnt);
            if (c > 5) rd16("external count", IDX_CNT_L, 16'(c - 4));
        end
        final_report();
    end
endmodule
`default_nettype wire
